// [sci_top.sv]
// status command interpreter: decoded commands in, formatted answers out
// Functional notes
// - fault sets condition only when mask enabled
// - mask bits 11,10,9,3,1,0 name conditions
// - mask write loads binary weights of value
// - mask query returns mask as weight sum
// - error query gives number and message; 0 none
// - bad syntax reports error -100
// - over-rating value reports -222 with quantity text
// - unresponsive supply reports error -240
// - language command CIIL switches decoder
// - back to SCPI only after GAL then SCPI
// - FNC SET programs, FNC VOLT/CURR reads
// - FNC device code must be DCS
// - FNC channel selects supply channel
// - INX starts acquisition per preceding FNC
// - INX answers time-out; nonzero means unsettled
// - catastrophic fault replaces INX/FTH answer
// - FTH returns reading in scientific notation
// - condition register holds live fault state
// - event bits clear once reported
`timescale 1ns/1ns
`default_nettype none
module sci_top (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // decoded command from the parser
  input  wire sci_pkg::sci_cmd_t   cmd,
  // supply side
  input  wire sci_pkg::sci_fault_t faults,
  input  wire logic [15:0]         max_volt,
  input  wire logic [15:0]         max_curr,
  input  wire logic [15:0]         meas_volt,
  input  wire logic [15:0]         meas_curr,
  input  wire logic                supply_ack,
  // answer to the parser
  output var  sci_pkg::sci_rsp_t   rsp,
  // supply programming
  output var  logic                prog_stb,
  output var  logic                prog_curr,
  output var  logic [4:0]          prog_channel,
  output var  logic [15:0]         prog_value,
  // status
  output var  logic                ciil_mode,
  output var  logic [11:0]         ques_cond
);
  typedef enum logic [1:0] {
    SCI_L_SCPI     = 2'b00,
    SCI_L_CIIL     = 2'b01,
    SCI_L_CIIL_GAL = 2'b11
  } sci_lang_t;

  typedef struct packed {
    sci_lang_t         lang;
    logic              fnc_ok;
    logic              fnc_curr;
    logic [4:0]        fnc_ch;
    logic              inx_done;
    logic              inx_curr;
    logic [15:0]       err_num;
    logic [1:0]        err_msg;
    sci_pkg::sci_rsp_t rsp;
    logic              prog_stb;
    logic              prog_curr;
    logic [4:0]        prog_ch;
    logic [15:0]       prog_value;
  } sci_state_t;

  sci_state_t  st, next_st;
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [11:0] mask;
  logic [11:0] cond;
  logic [11:0] evt;
  logic [15:0] remain;
  logic        no_response;
  logic        mask_wr;
  logic        evt_rd;
  logic        inx_go;
  logic        catastrophic;
  logic        legal;

  // reset released through two flops so release is clean
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  function automatic logic is_ciil_op(input sci_pkg::sci_op_t op);
    case (op)
      sci_pkg::SCI_OP_GAL, sci_pkg::SCI_OP_FNC_SET, sci_pkg::SCI_OP_FNC_READ,
      sci_pkg::SCI_OP_INX, sci_pkg::SCI_OP_FTH: is_ciil_op = 1'b1;
      default: is_ciil_op = 1'b0;
    endcase
  endfunction : is_ciil_op

  function automatic sci_pkg::sci_rsp_t mk_rsp(input sci_pkg::sci_rsp_kind_t kind,
                                               input logic [15:0] number,
                                               input logic [1:0] msg_sel);
    mk_rsp = '{valid: 1'b1, kind: kind, number: number, msg_sel: msg_sel,
               sci_notation: kind == sci_pkg::SCI_RSP_READ};
  endfunction : mk_rsp

  assign mask_wr = cmd.valid && cmd.op == sci_pkg::SCI_OP_MASK_WR && st.lang == SCI_L_SCPI;
  assign evt_rd  = cmd.valid && cmd.op == sci_pkg::SCI_OP_EVT_RD && st.lang == SCI_L_SCPI;
  assign inx_go  = cmd.valid && cmd.op == sci_pkg::SCI_OP_INX && st.lang != SCI_L_SCPI
                   && st.fnc_ok;
  // catastrophic: any supply fault present on the fault inputs right now, unregistered, masked or not
  assign catastrophic = |{faults.input_power_lost, faults.limit_exceeded, faults.relay_fault,
                          faults.thermal_fault, faults.curr_fault, faults.volts_fault};

  sci_qmask u_qmask (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr      (mask_wr),
    .wdata   (cmd.value[11:0]),
    .evt_rd  (evt_rd),
    .faults  (faults),
    .mask    (mask),
    .cond    (cond),
    .evt     (evt)
  );

  sci_settle u_settle (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .restart     (st.prog_stb),
    .supply_ack  (supply_ack),
    .cmd_sent    (st.prog_stb),
    .remain      (remain),
    .no_response (no_response)
  );

  always_comb begin
    next_st          = st;
    next_st.rsp      = '0;
    next_st.prog_stb = 1'b0;
    legal            = 1'b1;
    if (no_response) begin
      next_st.err_num = sci_pkg::ERR_HARDWARE;
      next_st.err_msg = 2'h3;
    end
    if (cmd.valid) begin
      if (st.lang == SCI_L_SCPI) begin
        case (cmd.op)
          sci_pkg::SCI_OP_MASK_WR: begin
            next_st.rsp.valid = 1'b0;
          end
          sci_pkg::SCI_OP_MASK_RD: begin
            // bits read back exactly as written, unused ones too
            next_st.rsp = mk_rsp(sci_pkg::SCI_RSP_VALUE, {4'h0, mask}, 2'h0);
          end
          sci_pkg::SCI_OP_EVT_RD: begin
            next_st.rsp = mk_rsp(sci_pkg::SCI_RSP_VALUE, {4'h0, evt}, 2'h0);
          end
          sci_pkg::SCI_OP_ERR_RD: begin
            next_st.rsp     = mk_rsp(sci_pkg::SCI_RSP_ERROR, st.err_num, st.err_msg);
            next_st.err_num = sci_pkg::ERR_NONE;
            next_st.err_msg = 2'h0;
          end
          sci_pkg::SCI_OP_LANG_CIIL: begin
            next_st.lang = SCI_L_CIIL;
          end
          default: begin
            legal = 1'b0;
          end
        endcase
      end else begin
        // only GAL arms the return; anything else in between disarms it
        if (st.lang == SCI_L_CIIL_GAL && cmd.op == sci_pkg::SCI_OP_SCPI) begin
          next_st.lang = SCI_L_SCPI;
        end else if (cmd.op == sci_pkg::SCI_OP_GAL) begin
          next_st.lang = SCI_L_CIIL_GAL;
        end else begin
          next_st.lang = SCI_L_CIIL;
        end
        if (cmd.op != sci_pkg::SCI_OP_INX) begin
          next_st.inx_done = 1'b0;
        end
        case (cmd.op)
          sci_pkg::SCI_OP_GAL, sci_pkg::SCI_OP_SCPI: begin
            legal = st.lang == SCI_L_CIIL_GAL || cmd.op == sci_pkg::SCI_OP_GAL;
          end
          sci_pkg::SCI_OP_FNC_SET, sci_pkg::SCI_OP_FNC_READ: begin
            if (cmd.dev_code != "DCS" || cmd.channel == 5'h00) begin
              legal          = 1'b0;
              next_st.fnc_ok = 1'b0;
            end else begin
              next_st.fnc_ok   = 1'b1;
              next_st.fnc_ch   = cmd.channel;
              next_st.fnc_curr = cmd.quantity_curr;
              if (cmd.op == sci_pkg::SCI_OP_FNC_SET) begin
                if (cmd.value > (cmd.quantity_curr ? max_curr : max_volt)) begin
                  next_st.err_num = sci_pkg::ERR_RANGE;
                  next_st.err_msg = cmd.quantity_curr ? 2'h2 : 2'h1;
                end else begin
                  next_st.prog_stb   = 1'b1;
                  next_st.prog_curr  = cmd.quantity_curr;
                  next_st.prog_ch    = cmd.channel;
                  next_st.prog_value = cmd.value;
                end
              end
            end
          end
          sci_pkg::SCI_OP_INX: begin
            if (!st.fnc_ok) begin
              legal = 1'b0;
            end else if (catastrophic) begin
              next_st.rsp      = mk_rsp(sci_pkg::SCI_RSP_ERROR, sci_pkg::ERR_HARDWARE,
                                        2'h3);
              next_st.inx_done = 1'b0;
            end else begin
              next_st.inx_done = 1'b1;
              next_st.inx_curr = cmd.quantity_curr;
              // settling runs from the last programming, so repeats count down
              next_st.rsp = mk_rsp(sci_pkg::SCI_RSP_TOUT,
                                   remain,
                                   2'h0);
            end
          end
          sci_pkg::SCI_OP_FTH: begin
            if (catastrophic) begin
              next_st.rsp = mk_rsp(sci_pkg::SCI_RSP_ERROR, sci_pkg::ERR_HARDWARE,
                                   2'h3);
            end else if (!st.inx_done || st.inx_curr != cmd.quantity_curr) begin
              legal = 1'b0;
            end else begin
              next_st.rsp = mk_rsp(sci_pkg::SCI_RSP_READ,
                                   st.inx_curr ? meas_curr : meas_volt,
                                   2'h0);
            end
          end
          default: begin
            legal = is_ciil_op(cmd.op);
          end
        endcase
      end
      if (!legal) begin
        next_st.err_num = sci_pkg::ERR_COMMAND;
        next_st.err_msg = 2'h0;
        if (st.lang != SCI_L_SCPI) begin
          next_st.rsp = mk_rsp(sci_pkg::SCI_RSP_ERROR, sci_pkg::ERR_COMMAND, 2'h0);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rsp          = st.rsp;
  assign prog_stb     = st.prog_stb;
  assign prog_curr    = st.prog_curr;
  assign prog_channel = st.prog_ch;
  assign prog_value   = st.prog_value;
  assign ciil_mode    = st.lang != SCI_L_SCPI;
  assign ques_cond    = cond;

  property p_ciil_entry;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmd.valid && cmd.op == sci_pkg::SCI_OP_LANG_CIIL && !ciil_mode) |=> ciil_mode;
  endproperty
  a_ciil_entry: assert property (p_ciil_entry) else $error("language switch ignored");

  property p_scpi_return;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmd.valid && cmd.op == sci_pkg::SCI_OP_SCPI && st.lang == SCI_L_CIIL_GAL)
        |=> !ciil_mode;
  endproperty
  a_scpi_return: assert property (p_scpi_return) else $error("scpi return malformed");

  property p_scpi_needs_gal;
    @(posedge clk_sys) disable iff (!rst_n)
      ($fell(ciil_mode)) |-> $past(st.lang, 2) == SCI_L_CIIL_GAL || $past(st.lang) == SCI_L_CIIL_GAL;
  endproperty
  a_scpi_needs_gal: assert property (p_scpi_needs_gal) else $error("left ciil without gal");

  property p_mask_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmd.valid && cmd.op == sci_pkg::SCI_OP_MASK_RD && !ciil_mode)
        |=> rsp.valid && rsp.number == {4'h0, mask};
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask query answer wrong");

  property p_bad_syntax;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmd.valid && cmd.op == sci_pkg::SCI_OP_BAD && !no_response)
        |=> st.err_num == sci_pkg::ERR_COMMAND;
  endproperty
  a_bad_syntax: assert property (p_bad_syntax) else $error("bad command not flagged");

  property p_fth_sci;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmd.valid && ciil_mode && cmd.op == sci_pkg::SCI_OP_FTH && !catastrophic && st.inx_done
       && st.inx_curr == cmd.quantity_curr)
        |=> rsp.valid && rsp.kind == sci_pkg::SCI_RSP_READ && rsp.sci_notation;
  endproperty
  a_fth_sci: assert property (p_fth_sci) else $error("reading not scientific");

  property p_catastrophic;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmd.valid && ciil_mode && cmd.op == sci_pkg::SCI_OP_FTH && catastrophic)
        |=> !(rsp.valid && rsp.kind == sci_pkg::SCI_RSP_READ);
  endproperty
  a_catastrophic: assert property (p_catastrophic) else $error("reading given under fault");

  property p_inx_tout;
    @(posedge clk_sys) disable iff (!rst_n)
      (inx_go && !catastrophic)
        |=> rsp.kind == sci_pkg::SCI_RSP_TOUT && rsp.number == $past(remain);
  endproperty
  a_inx_tout: assert property (p_inx_tout) else $error("inx time-out wrong");
endmodule : sci_top
`default_nettype wire

// [sci_pkg.sv]
// shared constants and carriers for the status command interpreter
package sci_pkg;
  localparam int          MASK_W         = 12;
  localparam int          BIT_PWR_LOSS   = 11;
  localparam int          BIT_OVERLOAD   = 10;
  localparam int          BIT_RELAY      = 9;
  localparam int          BIT_THERMAL    = 3;
  localparam int          BIT_CURR       = 1;
  localparam int          BIT_VOLT       = 0;
  localparam logic [11:0] MASK_USED      = 12'he0b;
  localparam logic [11:0] MASK_RESET     = 12'h000;
  localparam logic [15:0] ERR_NONE       = 16'h0000;
  localparam logic [15:0] ERR_COMMAND    = 16'hff9c;
  localparam logic [15:0] ERR_RANGE      = 16'hff22;
  localparam logic [15:0] ERR_HARDWARE   = 16'hff10;
  localparam logic [4:0]  MAX_CHANNEL    = 5'h1f;
  localparam int          SETTLE_NS      = 1000;
  localparam int          CLK_NS         = 4;
  localparam logic [15:0] SETTLE_CYCLES  = 16'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam int          RESP_NS        = 2000;
  localparam logic [15:0] RESP_CYCLES    = 16'(RESP_NS / CLK_NS);

  typedef enum logic [3:0] {
    SCI_OP_NONE      = 4'h0,
    SCI_OP_MASK_WR   = 4'h1,
    SCI_OP_MASK_RD   = 4'h2,
    SCI_OP_ERR_RD    = 4'h3,
    SCI_OP_LANG_CIIL = 4'h4,
    SCI_OP_GAL       = 4'h5,
    SCI_OP_SCPI      = 4'h6,
    SCI_OP_FNC_SET   = 4'h7,
    SCI_OP_FNC_READ  = 4'h8,
    SCI_OP_INX       = 4'h9,
    SCI_OP_FTH       = 4'ha,
    SCI_OP_EVT_RD    = 4'hb,
    SCI_OP_BAD       = 4'hf
  } sci_op_t;

  typedef enum logic [1:0] {
    SCI_RSP_VALUE = 2'h0,
    SCI_RSP_ERROR = 2'h1,
    SCI_RSP_TOUT  = 2'h2,
    SCI_RSP_READ  = 2'h3
  } sci_rsp_kind_t;

  // decoded command from the text parser
  typedef struct packed {
    logic          valid;
    sci_op_t       op;
    logic [23:0]   dev_code;
    logic          quantity_curr;
    logic [4:0]    channel;
    logic [15:0]   value;
  } sci_cmd_t;

  // answer to the parser for formatting
  typedef struct packed {
    logic          valid;
    sci_rsp_kind_t kind;
    logic [15:0]   number;
    logic [1:0]    msg_sel;
    logic          sci_notation;
  } sci_rsp_t;

  // supply-side fault levels
  typedef struct packed {
    logic input_power_lost;
    logic limit_exceeded;
    logic relay_fault;
    logic thermal_fault;
    logic curr_fault;
    logic volts_fault;
  } sci_fault_t;
endpackage : sci_pkg

// [sci_qmask.sv]
// questionable enable mask, live condition gating and event latch
`timescale 1ns/1ns
`default_nettype none
module sci_qmask (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // mask access
  input  wire logic              wr,
  input  wire logic [11:0]       wdata,
  input  wire logic              evt_rd,
  input  wire sci_pkg::sci_fault_t faults,
  // results
  output var  logic [11:0]       mask,
  output var  logic [11:0]       cond,
  output var  logic [11:0]       evt
);
  typedef struct packed {
    logic [11:0] mask;
    logic [11:0] cond;
    logic [11:0] evt;
  } sci_qm_state_t;

  sci_qm_state_t st, next_st;
  logic [11:0]   raw;

  always_comb begin
    raw = '0;
    raw[sci_pkg::BIT_PWR_LOSS] = faults.input_power_lost;
    raw[sci_pkg::BIT_OVERLOAD] = faults.limit_exceeded;
    raw[sci_pkg::BIT_RELAY]    = faults.relay_fault;
    raw[sci_pkg::BIT_THERMAL]  = faults.thermal_fault;
    raw[sci_pkg::BIT_CURR]     = faults.curr_fault;
    raw[sci_pkg::BIT_VOLT]     = faults.volts_fault;
    next_st = st;
    if (wr) begin
      next_st.mask = wdata;
    end
    // live, unlatched; unused positions never gate
    next_st.cond = raw & st.mask & sci_pkg::MASK_USED;
    // new condition wins over the read-clear
    next_st.evt = (evt_rd ? 12'h000 : st.evt) | (next_st.cond & ~st.cond);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{mask: sci_pkg::MASK_RESET, cond: 12'h000, evt: 12'h000};
    end else begin
      st <= next_st;
    end
  end

  assign mask = st.mask;
  assign cond = st.cond;
  assign evt  = st.evt;

  property p_gate;
    @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> (cond & ~($past(st.mask) & sci_pkg::MASK_USED)) == 12'h000;
  endproperty
  a_gate: assert property (p_gate) else $error("condition set with mask bit clear");
endmodule : sci_qmask
`default_nettype wire

// [sci_settle.sv]
// settle timer for acquisitions and supply response watchdog for programming strobes
`timescale 1ns/1ns
`default_nettype none
module sci_settle (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // control
  input  wire logic        restart,
  input  wire logic        supply_ack,
  input  wire logic        cmd_sent,
  // status
  output var  logic [15:0] remain,
  output var  logic        no_response
);
  typedef struct packed {
    logic [15:0] remain;
    logic [15:0] wd;
    logic        wd_run;
    logic        no_response;
  } sci_st_state_t;

  sci_st_state_t st, next_st;

  always_comb begin
    next_st = st;
    // one-cycle pulse, so an error query can clear the stored error
    next_st.no_response = 1'b0;
    if (restart) begin
      next_st.remain = sci_pkg::SETTLE_CYCLES;
    end else if (st.remain != 16'h0000) begin
      next_st.remain = st.remain - 16'h0001;
    end
    if (cmd_sent) begin
      next_st.wd          = sci_pkg::RESP_CYCLES;
      next_st.wd_run      = 1'b1;
      next_st.no_response = 1'b0;
    end else if (supply_ack) begin
      next_st.wd_run = 1'b0;
    end else if (st.wd_run && st.wd == 16'h0000) begin
      next_st.wd_run      = 1'b0;
      next_st.no_response = 1'b1;
    end else if (st.wd_run) begin
      next_st.wd = st.wd - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{remain: 16'h0000, wd: 16'h0000, wd_run: 1'b0, no_response: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign remain      = st.remain;
  assign no_response = st.no_response;

  property p_restart;
    @(posedge clk_sys) disable iff (!rst_n)
      restart |=> remain == sci_pkg::SETTLE_CYCLES;
  endproperty
  a_restart: assert property (p_restart) else $error("settle timer not reloaded");
endmodule : sci_settle
`default_nettype wire

// [sci_ctrl_model.sv]
// controller model: sends decoded commands one at a time and collects answers
`timescale 1ns/1ns
`default_nettype none
module sci_ctrl_model (
  // clock
  input  wire logic              clk_sys,
  // command out, answer in
  output var  sci_pkg::sci_cmd_t cmd,
  input  wire sci_pkg::sci_rsp_t rsp
);
  logic [23:0] dev = 24'h444353;

  initial cmd = '0;

  // a gap edge follows each command, so valid never toggles twice in one step
  task automatic send(input sci_pkg::sci_op_t op, input logic q, input logic [4:0] ch,
                      input logic [15:0] v);
    @(negedge clk_sys);
    cmd <= '{1'b1, op, dev, q, ch, v};
    @(negedge clk_sys);
    cmd.valid <= 1'b0;
  endtask : send

  // answer may land up to four edges after the command
  task automatic ask(input sci_pkg::sci_op_t op, input logic q, input logic [4:0] ch,
                     input logic [15:0] v, output sci_pkg::sci_rsp_t r);
    r = '0;
    send(op, q, ch, v);
    repeat (4) begin
      if (rsp.valid === 1'b1 && r.valid !== 1'b1) r = rsp;
      @(posedge clk_sys);
      #1;
    end
  endtask : ask

  task automatic leave_ciil;
    send(sci_pkg::SCI_OP_GAL, 1'b0, 5'h00, 16'h0000);
    send(sci_pkg::SCI_OP_SCPI, 1'b0, 5'h00, 16'h0000);
    repeat (2) @(posedge clk_sys);
  endtask : leave_ciil

  // waits out the quoted time, repeats setup and start, then fetches at once
  task automatic measure(input logic q, input logic [4:0] ch, output logic [15:0] t0,
                         output sci_pkg::sci_rsp_t r);
    ask(sci_pkg::SCI_OP_FNC_READ, q, ch, 16'h0000, r);
    ask(sci_pkg::SCI_OP_INX, q, ch, 16'h0000, r);
    t0 = r.number;
    for (int n = 0; n < 4 && r.kind === sci_pkg::SCI_RSP_TOUT && r.number !== 0; n++) begin
      repeat (int'(r.number) + 4) @(posedge clk_sys);
      ask(sci_pkg::SCI_OP_FNC_READ, q, ch, 16'h0000, r);
      ask(sci_pkg::SCI_OP_INX, q, ch, 16'h0000, r);
    end
    ask(sci_pkg::SCI_OP_FTH, q, ch, 16'h0000, r);
  endtask : measure
endmodule : sci_ctrl_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the status command interpreter
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                clk_sys    = 1'b0;
  logic                resetn     = 1'b0;
  sci_pkg::sci_cmd_t   cmd;
  sci_pkg::sci_fault_t faults     = '0;
  logic                supply_ack = 1'b0;
  logic                ack_on     = 1'b1;
  logic                stb_seen   = 1'b0;
  sci_pkg::sci_rsp_t   rsp;
  sci_pkg::sci_rsp_t   r;
  logic                prog_stb;
  logic                prog_curr;
  logic [4:0]          prog_channel;
  logic [15:0]         prog_value;
  logic                ciil_mode;
  logic [11:0]         ques_cond;
  logic [15:0]         t0;
  int                  n_errors   = 0;
  int                  compares   = 0;
  int                  stbs       = 0;

  always #2 clk_sys = ~clk_sys;

  sci_top i_sci_top (
    .clk_sys(clk_sys), .resetn(resetn), .cmd(cmd), .faults(faults),
    .max_volt(16'h0064), .max_curr(16'h000a), .meas_volt(16'h1234), .meas_curr(16'h0567),
    .supply_ack(supply_ack), .rsp(rsp), .prog_stb(prog_stb), .prog_curr(prog_curr),
    .prog_channel(prog_channel), .prog_value(prog_value), .ciil_mode(ciil_mode),
    .ques_cond(ques_cond));
  sci_ctrl_model i_sci_ctrl_model (.clk_sys(clk_sys), .cmd(cmd), .rsp(rsp));

  // supply answers once the strobe has been seen, unless kept mute
  always @(negedge clk_sys) begin
    stb_seen   <= prog_stb === 1'b1;
    supply_ack <= ack_on && stb_seen;
    if (prog_stb === 1'b1) stbs++;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic ask(input sci_pkg::sci_op_t op, input logic q = 1'b0,
                     input logic [4:0] ch = 5'h00, input logic [15:0] v = 16'h0000);
    i_sci_ctrl_model.ask(op, q, ch, v, r);
  endtask : ask

  // condition register is registered, so let it land before looking
  task automatic flt(input logic [5:0] f);
    @(negedge clk_sys);
    faults = sci_pkg::sci_fault_t'(f);
    repeat (3) @(negedge clk_sys);
  endtask : flt

  task automatic t_err;
    ask(sci_pkg::SCI_OP_ERR_RD);
    check("err none", sci_pkg::ERR_NONE, r.number);
    ask(sci_pkg::SCI_OP_BAD);
    ask(sci_pkg::SCI_OP_ERR_RD);
    check("err cmd", sci_pkg::ERR_COMMAND, r.number);
    check("err cmd text", 16'h0000, {14'h0, r.msg_sel});
    ask(sci_pkg::SCI_OP_ERR_RD);
    check("err cleared", sci_pkg::ERR_NONE, r.number);
    $display("test err done");
  endtask : t_err

  task automatic t_mask;
    logic [15:0] vals [3] = '{16'h0e0b, 16'h0fff, 16'h0404};
    ask(sci_pkg::SCI_OP_MASK_RD);
    check("mask reset", {4'h0, sci_pkg::MASK_RESET}, r.number);
    foreach (vals[i]) begin
      ask(sci_pkg::SCI_OP_MASK_WR, 1'b0, 5'h00, vals[i]);
      ask(sci_pkg::SCI_OP_MASK_RD);
      check("mask readback", vals[i], r.number);
    end
    $display("test mask done");
  endtask : t_mask

  task automatic t_gate;
    int pos [6] = '{0, 1, 3, 9, 10, 11};
    ask(sci_pkg::SCI_OP_MASK_WR, 1'b0, 5'h00, 16'h000f);
    flt(6'h3f);
    check("cond gated", 16'h000b, {4'h0, ques_cond});
    ask(sci_pkg::SCI_OP_MASK_WR, 1'b0, 5'h00, 16'h0fff);
    for (int i = 0; i < 6; i++) begin
      flt(6'(1 << i));
      check("cond bit", 16'(1 << pos[i]), {4'h0, ques_cond});
    end
    flt(6'h00);
    ask(sci_pkg::SCI_OP_EVT_RD);
    flt(6'h04);
    ask(sci_pkg::SCI_OP_EVT_RD);
    check("event set", 16'h0008, r.number);
    ask(sci_pkg::SCI_OP_EVT_RD);
    check("event cleared", 16'h0000, r.number);
    flt(6'h00);
    check("cond live", 16'h0000, {4'h0, ques_cond});
    $display("test gate done");
  endtask : t_gate

  task automatic t_lang;
    ask(sci_pkg::SCI_OP_LANG_CIIL);
    check("ciil on", 16'h0001, {15'h0, ciil_mode});
    ask(sci_pkg::SCI_OP_MASK_RD);
    check("scpi op refused", sci_pkg::ERR_COMMAND, r.number);
    ask(sci_pkg::SCI_OP_SCPI);
    check("scpi alone", 16'h0001, {15'h0, ciil_mode});
    i_sci_ctrl_model.leave_ciil();
    check("ciil off", 16'h0000, {15'h0, ciil_mode});
    $display("test lang done");
  endtask : t_lang

  task automatic t_prog;
    int s;
    ask(sci_pkg::SCI_OP_LANG_CIIL);
    s = stbs;
    ask(sci_pkg::SCI_OP_FNC_SET, 1'b0, 5'h03, 16'h0005);
    check("volt set", 16'h0005, prog_value);
    check("volt chan", 16'h0003, {11'h0, prog_channel});
    check("volt mode", 16'h0000, {15'h0, prog_curr});
    ask(sci_pkg::SCI_OP_FNC_SET, 1'b1, 5'h1f, 16'h000a);
    check("curr mode", 16'h0001, {15'h0, prog_curr});
    check("curr chan", 16'h001f, {11'h0, prog_channel});
    i_sci_ctrl_model.dev = 24'h585958;
    ask(sci_pkg::SCI_OP_FNC_SET, 1'b0, 5'h01, 16'h0001);
    i_sci_ctrl_model.dev = 24'h444353;
    ask(sci_pkg::SCI_OP_FNC_SET, 1'b0, 5'h00, 16'h0001);
    ask(sci_pkg::SCI_OP_FNC_SET, 1'b0, 5'h01, 16'h0065);
    check("strobes", 16'h0002, 16'(stbs - s));
    i_sci_ctrl_model.leave_ciil();
    ask(sci_pkg::SCI_OP_ERR_RD);
    check("range err", sci_pkg::ERR_RANGE, r.number);
    check("range text", 16'h0001, {14'h0, r.msg_sel});
    $display("test prog done");
  endtask : t_prog

  task automatic t_meas;
    ask(sci_pkg::SCI_OP_LANG_CIIL);
    ask(sci_pkg::SCI_OP_FNC_SET, 1'b0, 5'h02, 16'h0005);
    i_sci_ctrl_model.measure(1'b0, 5'h02, t0, r);
    check("settling", 16'h0001, {15'h0, t0 !== 16'h0000});
    check("volt kind", {14'h0, sci_pkg::SCI_RSP_READ}, {14'h0, r.kind});
    check("volt read", 16'h1234, r.number);
    check("sci form", 16'h0001, {15'h0, r.sci_notation});
    i_sci_ctrl_model.measure(1'b1, 5'h02, t0, r);
    check("settled", 16'h0000, t0);
    check("curr read", 16'h0567, r.number);
    ask(sci_pkg::SCI_OP_FTH);
    check("lone fetch", sci_pkg::ERR_COMMAND, r.number);
    flt(6'h04);
    i_sci_ctrl_model.measure(1'b0, 5'h02, t0, r);
    check("inx fault", sci_pkg::ERR_HARDWARE, t0);
    check("fth fault", sci_pkg::ERR_HARDWARE, r.number);
    flt(6'h00);
    i_sci_ctrl_model.leave_ciil();
    $display("test meas done");
  endtask : t_meas

  task automatic t_hang;
    ack_on = 1'b0;
    ask(sci_pkg::SCI_OP_LANG_CIIL);
    ask(sci_pkg::SCI_OP_FNC_SET, 1'b0, 5'h01, 16'h0005);
    repeat (520) @(negedge clk_sys);
    ack_on = 1'b1;
    i_sci_ctrl_model.leave_ciil();
    ask(sci_pkg::SCI_OP_ERR_RD);
    check("no answer", sci_pkg::ERR_HARDWARE, r.number);
    check("no answer text", 16'h0003, {14'h0, r.msg_sel});
    $display("test hang done");
  endtask : t_hang

  initial begin
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_err();
    t_mask();
    t_gate();
    t_lang();
    t_prog();
    t_meas();
    t_hang();
    stop_test();
  end

  // all scenarios need roughly a thousand cycles; this allows 25000, over twenty times that
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
